// File: pkg/pci_vq_event_notify_defs.vh
`ifndef PCI_VQ_EVENT_NOTIFY_DEFS_VH
`define PCI_VQ_EVENT_NOTIFY_DEFS_VH
// ==========================================================
// Register byte offsets on the Wishbone slave
`define OFS_FEATURE_CTRL 8'h00
`define OFS_RING_CHOOSER 8'h04
`define OFS_QUEUE_DEPTH 8'h08
`define OFS_RING_BASE 8'h0c
`define OFS_CONFIG_VECTOR 8'h10
`define OFS_QUEUE_VECTOR 8'h14
`define OFS_DOORBELL 8'h18
`define OFS_CAUSE 8'h1c
`define OFS_TABLE_SIZE 8'h20
// ==========================================================
// Feature control bit positions
`define FEAT_EXT_NOTIFY 0
`define FEAT_NOTIFY_COOKIE 1
// Interrupt cause bit positions
`define CAUSE_USED 0
`define CAUSE_CONFIG 1
// ==========================================================
// Vector codes and limits
`define VECTOR_UNMAPPED_CODE 16'hffff
`define VECTOR_ENTRY_MAX 16'h07ff
`define VECTOR_COUNT_DEFAULT 8
`define QUEUE_COUNT_DEFAULT 4
`define QUEUE_SIZE_DEFAULT 16'h0100
// Legacy ring alignment in bytes, page number shift
`define RING_ALIGN_BYTES 4096
`define RING_ALIGN_SHIFT 12
// Doorbell field layout
`define DB_ID_LSB 0
`define DB_ID_MSB 15
`define DB_OFF_LSB 16
`define DB_OFF_MSB 30
`define DB_WRAP_BIT 31
`endif

// File: hdl/queue_reg_bank.v
`timescale 1ns/10ps
module queue_reg_bank #(
  parameter DEPTH = 4,
  parameter IDXW = 2,
  parameter WIDTH = 16,
  parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Write port
  input wire writeEnable,
  input wire [IDXW-1:0] writeIndex,
  input wire [WIDTH-1:0] writeData,
  // Two read ports
  input wire [IDXW-1:0] readIndexA,
  output wire [WIDTH-1:0] readDataA,
  input wire [IDXW-1:0] readIndexB,
  output wire [WIDTH-1:0] readDataB
);
  wire [WIDTH*DEPTH-1:0] flat;

  // ========================================================
  // One flip-flop word per queue, loaded with RESET_VALUE on reset
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : gEntry
      reg [WIDTH-1:0] word;
      always @(posedge clock) begin
        if (rst) begin
          word <= RESET_VALUE;
        end else if (writeEnable && writeIndex == i) begin
          word <= writeData;
        end
      end
      assign flat[i*WIDTH +: WIDTH] = word;
    end
  endgenerate

  // Index out of range is filtered by the caller
  assign readDataA = flat[readIndexA*WIDTH +: WIDTH];
  assign readDataB = flat[readIndexB*WIDTH +: WIDTH];
endmodule

// File: hdl/pci_vq_event_notify_logic.v
// Behaviour
// - Vector write 0..0x7ff routes event to vector
// - Unmapped code 0xffff disables event interrupts
// - Implement between 2 and 0x800 vectors
// - Advertise vector count minus one as table size
// - Accept any in-table mapping and unmapping
// - Vector read returns mapping or unmapped code
// - Reset unmaps every queue and config event
// - Impossible mapping reads back unmapped code
// - Cause register unused while messages enabled
// - Depth reads selected queue size, zero absent
// - Ring base is page number, 4096 aligned
// - Plain doorbell is one 16-bit write
// - Extended doorbell: id, offset, wrap bits
// - Used event sets cause bit0, line irq
// - Used event sends queue vector, unless unmapped
// - Config change sets cause bit1, line irq
// - Config change sends config vector if mapped
// - Cause read returns bits, then clears all
// - Legacy registers sit in I/O region zero
`timescale 1ns/10ps
`include "pci_vq_event_notify_defs.vh"
module pci_vq_event_notify_logic #(
  parameter NUM_VECTORS = `VECTOR_COUNT_DEFAULT,
  parameter NUM_QUEUES = `QUEUE_COUNT_DEFAULT,
  parameter QW = 2,
  parameter [15:0] QUEUE_SIZE_MAX = `QUEUE_SIZE_DEFAULT
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Message interrupt enable from PCI configuration space
  input wire msgEnable,
  // Device events
  input wire usedEvent,
  input wire [QW-1:0] usedQueue,
  input wire configChangeEvent,
  // Interrupt delivery
  output wire lineIrq,
  output reg msgRequest,
  output reg [10:0] msgVector,
  output wire [10:0] msgTableSize,
  // Decoded doorbell
  output reg doorbellValid,
  output reg doorbellExtended,
  output reg doorbellIsCookie,
  output reg [15:0] doorbell_queue_id,
  output reg [14:0] doorbellNextOff,
  output reg doorbellWrap,
  // Queue setup as seen by ring processing
  output wire [QW-1:0] ringChooser,
  output wire [31:0] ringBaseBytes
);
  // ========================================================
  // Legacy window decode
  wire busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wrReq = busReq && wb_we_i;
  wire rdReq = busReq && !wb_we_i;
  wire lowHalf = wb_sel_i[1:0] == 2'h3;
  wire fullWord = wb_sel_i == 4'hf;
  wire hitFeat = wb_adr_i == `OFS_FEATURE_CTRL;
  wire hitChooser = wb_adr_i == `OFS_RING_CHOOSER;
  wire hitDepth = wb_adr_i == `OFS_QUEUE_DEPTH;
  wire hitBase = wb_adr_i == `OFS_RING_BASE;
  wire hitCfgVec = wb_adr_i == `OFS_CONFIG_VECTOR;
  wire hitQVec = wb_adr_i == `OFS_QUEUE_VECTOR;
  wire hitBell = wb_adr_i == `OFS_DOORBELL;
  wire hitCause = wb_adr_i == `OFS_CAUSE;
  wire hitTable = wb_adr_i == `OFS_TABLE_SIZE;

  // ========================================================
  // Control state
  reg [1:0] featureCtrl;
  reg [15:0] chooser;
  reg [15:0] configVector;
  reg [1:0] cause;
  reg pendConfigMsg;
  reg [10:0] pendConfigVec;

  // Chooser beyond the queue count names no queue
  wire queueExists = chooser < NUM_QUEUES;
  wire [QW-1:0] chooserIdx = chooser[QW-1:0];
  assign ringChooser = chooserIdx;

  // Vector count bounds
  // Table size field holds count minus one; the count is
  // meant to lie in 2..0x800, so the field fits 11 bits.
  localparam integer TABLE_COUNT = NUM_VECTORS - 1;
  localparam [15:0] TABLE_FIELD = TABLE_COUNT[15:0];
  assign msgTableSize = TABLE_FIELD[10:0];

  // Refuse only impossible mappings
  // A vector past the table cannot be served; it is stored
  // as the unmapped code so the read-back shows failure.
  function [15:0] vecAccept;
    input [15:0] req;
    begin
      if (req == `VECTOR_UNMAPPED_CODE) begin
        vecAccept = `VECTOR_UNMAPPED_CODE;
      end else if (req <= TABLE_FIELD &&
                   req <= `VECTOR_ENTRY_MAX) begin
        vecAccept = req;
      end else begin
        vecAccept = `VECTOR_UNMAPPED_CODE;
      end
    end
  endfunction

  // ========================================================
  // Per-queue banks: vector, depth and ring page
  wire [15:0] selQVec;
  wire [15:0] usedQVec;
  wire [15:0] selDepth;
  wire [31:0] selBase;
  wire qVecWrite = wrReq && hitQVec && lowHalf && queueExists;
  wire [15:0] wrDepth = wb_dat_i[15:0];
  wire depthOk = wrDepth != 16'h0000 && wrDepth <= QUEUE_SIZE_MAX;
  wire depthWrite = wrReq && hitDepth && lowHalf && queueExists &&
                    depthOk;
  wire baseWrite = wrReq && hitBase && fullWord && queueExists;
  wire [QW-1:0] unusedIdx = {QW{1'b0}};

  queue_reg_bank #(
    .DEPTH(NUM_QUEUES),
    .IDXW(QW),
    .WIDTH(16),
    .RESET_VALUE(`VECTOR_UNMAPPED_CODE)
  ) uQueueVec (
    .clock(clock),
    .rst(rst),
    .writeEnable(qVecWrite),
    .writeIndex(chooserIdx),
    .writeData(vecAccept(wb_dat_i[15:0])),
    .readIndexA(chooserIdx),
    .readDataA(selQVec),
    .readIndexB(usedQueue),
    .readDataB(usedQVec)
  );

  // Driver may shrink a queue, never grow it past the maximum
  queue_reg_bank #(
    .DEPTH(NUM_QUEUES),
    .IDXW(QW),
    .WIDTH(16),
    .RESET_VALUE(QUEUE_SIZE_MAX)
  ) uDepth (
    .clock(clock),
    .rst(rst),
    .writeEnable(depthWrite),
    .writeIndex(chooserIdx),
    .writeData(wrDepth),
    .readIndexA(chooserIdx),
    .readDataA(selDepth),
    .readIndexB(unusedIdx),
    .readDataB()
  );

  queue_reg_bank #(
    .DEPTH(NUM_QUEUES),
    .IDXW(QW),
    .WIDTH(32),
    .RESET_VALUE(32'h00000000)
  ) uBase (
    .clock(clock),
    .rst(rst),
    .writeEnable(baseWrite),
    .writeIndex(chooserIdx),
    .writeData(wb_dat_i),
    .readIndexA(chooserIdx),
    .readDataA(selBase),
    .readIndexB(unusedIdx),
    .readDataB()
  );

  // Page number to byte address
  // No size negotiation in this path; the upper page bits
  // fall off, which limits legacy rings to 4 GiB.
  assign ringBaseBytes = {selBase[31-`RING_ALIGN_SHIFT:0],
                          {`RING_ALIGN_SHIFT{1'b0}}};

  // ========================================================
  // Software-written control registers
  always @(posedge clock) begin
    if (rst) begin
      featureCtrl <= 2'h0;
      chooser <= 16'h0000;
      configVector <= `VECTOR_UNMAPPED_CODE;
    end else if (wrReq) begin
      if (hitFeat && wb_sel_i[0]) begin
        featureCtrl <= wb_dat_i[1:0];
      end
      if (hitChooser && lowHalf) begin
        chooser <= wb_dat_i[15:0];
      end
      // Any in-table vector or unmap taken
      if (hitCfgVec && lowHalf) begin
        configVector <= vecAccept(wb_dat_i[15:0]);
      end
    end
  end

  // ========================================================
  // Read data mux, registered with the ack
  reg [31:0] readMux;
  always @* begin
    readMux = 32'h00000000;
    case (1'b1)
      hitFeat: readMux = {30'h00000000, featureCtrl};
      hitChooser: readMux = {16'h0000, chooser};
      hitDepth: readMux = queueExists ? {16'h0000, selDepth} :
                                         32'h00000000;
      hitBase: readMux = queueExists ? selBase : 32'h00000000;
      hitCfgVec: readMux = {16'h0000, configVector};
      hitQVec: readMux = {16'h0000, queueExists ? selQVec :
                                     `VECTOR_UNMAPPED_CODE};
      hitCause: readMux = {30'h00000000, cause};
      hitTable: readMux = {16'h0000, TABLE_FIELD};
      default: readMux = 32'h00000000;
    endcase
  end

  // Ack one cycle after the request; unmapped offsets read
  // zero and swallow writes, so the bus never hangs.
  always @(posedge clock) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (rdReq) begin
        wb_dat_o <= readMux;
      end
    end
  end

  // ========================================================
  // Interrupt cause register
  wire causeRead = rdReq && hitCause;
  reg [1:0] next_cause;
  always @* begin
    next_cause = cause;
    if (causeRead) begin
      next_cause = 2'h0;
    end
    // Set after clear: an event in the read cycle survives
    // Events leave cause untouched in message mode
    if (!msgEnable) begin
      if (usedEvent) begin
        next_cause[`CAUSE_USED] = 1'b1;
      end
      if (configChangeEvent) begin
        next_cause[`CAUSE_CONFIG] = 1'b1;
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      cause <= 2'h0;
    end else begin
      cause <= next_cause;
    end
  end

  // Line interrupt follows cause
  // Masked in message mode so stale bits never raise it
  assign lineIrq = !msgEnable && (cause != 2'h0);

  // ========================================================
  // Message requests. A used event wins the cycle; a config
  // change arriving with it is held until a cycle with no used message.
  wire usedMapped = usedQVec != `VECTOR_UNMAPPED_CODE &&
                    usedQueue < NUM_QUEUES;
  wire cfgMapped = configVector != `VECTOR_UNMAPPED_CODE;
  wire sendUsed = msgEnable && usedEvent && usedMapped;
  wire sendCfgNow = msgEnable && configChangeEvent && cfgMapped;
  always @(posedge clock) begin
    if (rst) begin
      msgRequest <= 1'b0;
      msgVector <= 11'h000;
      pendConfigMsg <= 1'b0;
      pendConfigVec <= 11'h000;
    end else begin
      msgRequest <= 1'b0;
      if (sendUsed) begin
        msgRequest <= 1'b1;
        msgVector <= usedQVec[10:0];
      end else if (pendConfigMsg) begin
        msgRequest <= 1'b1;
        msgVector <= pendConfigVec;
      end else if (sendCfgNow) begin
        msgRequest <= 1'b1;
        msgVector <= configVector[10:0];
      end
      // Hold the config message while the slot is taken
      if (sendUsed && (sendCfgNow || pendConfigMsg)) begin
        pendConfigMsg <= 1'b1;
        if (!pendConfigMsg) begin
          pendConfigVec <= configVector[10:0];
        end
      end else if (!sendUsed) begin
        pendConfigMsg <= 1'b0;
      end
      if (!msgEnable) begin
        pendConfigMsg <= 1'b0;
      end
    end
  end

  // ========================================================
  // Doorbell decode
  wire bellWrite = wrReq && hitBell;
  wire extMode = featureCtrl[`FEAT_EXT_NOTIFY];
  always @(posedge clock) begin
    if (rst) begin
      doorbellValid <= 1'b0;
      doorbellExtended <= 1'b0;
      doorbellIsCookie <= 1'b0;
      doorbell_queue_id <= 16'h0000;
      doorbellNextOff <= 15'h0000;
      doorbellWrap <= 1'b0;
    end else begin
      doorbellValid <= 1'b0;
      if (bellWrite && extMode && fullWord) begin
        doorbellValid <= 1'b1;
        doorbellExtended <= 1'b1;
        doorbell_queue_id <= wb_dat_i[`DB_ID_MSB:`DB_ID_LSB];
        doorbellNextOff <= wb_dat_i[`DB_OFF_MSB:`DB_OFF_LSB];
        doorbellWrap <= wb_dat_i[`DB_WRAP_BIT];
      end else if (bellWrite && !extMode && lowHalf) begin
        doorbellValid <= 1'b1;
        doorbellExtended <= 1'b0;
        doorbell_queue_id <= wb_dat_i[`DB_ID_MSB:`DB_ID_LSB];
        doorbellNextOff <= 15'h0000;
        doorbellWrap <= 1'b0;
      end
      if (bellWrite) begin
        doorbellIsCookie <= featureCtrl[`FEAT_NOTIFY_COOKIE];
      end
    end
  end
endmodule

// File: verification/pci_vq_event_notify_logic_properties.sv
`timescale 1ns/10ps
`include "pci_vq_event_notify_defs.vh"
// ==========================================================
// Port checker for the event and notify logic
module pci_vq_event_notify_logic_properties #(
  parameter NUM_VECTORS = 8,
  parameter QW = 2
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire wb_ack_o,
  // Events and delivery
  input wire msgEnable,
  input wire usedEvent,
  input wire configChangeEvent,
  input wire lineIrq,
  input wire msgRequest,
  input wire [10:0] msgVector,
  input wire [10:0] msgTableSize,
  input wire doorbellValid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // A taken request gets exactly one ack pulse on the next edge
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack late or stuck");
  // Messages replace the line interrupt
  line_masked_a: assert property (msgEnable |-> !lineIrq)
    else $error("line interrupt while messages on");
  used_line_a: assert property (!msgEnable && usedEvent
    ##1 !msgEnable |-> lineIrq) else $error("used event gave no line");
  config_line_a: assert property (!msgEnable && configChangeEvent
    ##1 !msgEnable |-> lineIrq) else $error("config change gave no line");
  // Line stays up until something on the bus clears the cause
  line_hold_a: assert property (lineIrq && !wb_cyc_i
    ##1 !msgEnable |-> lineIrq) else $error("line dropped without read");
  // A message needs an event shortly before and message mode
  msg_cause_a: assert property (msgRequest |-> $past(msgEnable) &&
    ($past(usedEvent) || $past(configChangeEvent) ||
    $past(configChangeEvent, 2))) else $error("message without event");
  msg_range_a: assert property (msgRequest
    |-> msgVector <= msgTableSize) else $error("vector beyond table");
  table_size_a: assert property (msgTableSize == NUM_VECTORS - 1)
    else $error("table size wrong");
  doorbell_pulse_a: assert property (doorbellValid |-> wb_ack_o &&
    $past(wb_we_i && wb_adr_i == `OFS_DOORBELL) ##1 !doorbellValid)
    else $error("doorbell pulse without doorbell write");
endmodule
bind pci_vq_event_notify_logic pci_vq_event_notify_logic_properties #(
  .NUM_VECTORS(NUM_VECTORS), .QW(QW)) i_props (.clock(clock), .rst(rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .msgEnable(msgEnable),
  .usedEvent(usedEvent), .configChangeEvent(configChangeEvent),
  .lineIrq(lineIrq), .msgRequest(msgRequest), .msgVector(msgVector),
  .msgTableSize(msgTableSize), .doorbellValid(doorbellValid));

// File: verification/host_driver_model.sv
`timescale 1ns/10ps
`include "pci_vq_event_notify_defs.vh"
// ==========================================================
// Host driver: classic Wishbone master, one cycle at a time
module host_driver_model (
  // Clock
  input wire clock,
  // Answer from the device
  input wire ack,
  input wire [31:0] datIn,
  // Request
  output logic cyc = 1'b0,
  output logic stb = 1'b0,
  output logic we = 1'b0,
  output logic [7:0] adr = 8'h00,
  output logic [3:0] sel = 4'h0,
  output logic [31:0] datOut = 32'h0
);
  // Held until ack is sampled; released address and data show the inverse
  task automatic access(input logic w, input logic [7:0] a,
      input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    datOut <= d;
    do @(posedge clock); while (ack !== 1'b1);
    q = datIn;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    datOut <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] q;
    access(1'b1, a, s, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    access(1'b0, a, 4'hf, 32'h0, q);
  endtask
  task automatic mapVector(input logic [7:0] a, input logic [15:0] v,
      output logic [31:0] q);
    wr(a, {16'h0000, v}, 4'hf);
    rd(a, q);
  endtask
  task automatic ring(input logic ext, input logic [15:0] id,
      input logic [14:0] off, input logic wrap);
    if (ext) wr(`OFS_DOORBELL, {wrap, off, id}, 4'hf);
    else wr(`OFS_DOORBELL, {16'h0000, id}, 4'h3);
  endtask
endmodule

// File: verification/pci_vq_event_notify_logic_bench.sv
`timescale 1ns/10ps
`include "pci_vq_event_notify_defs.vh"
// ==========================================================
// Bench for the event and notify logic
module pci_vq_event_notify_logic_bench;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic msgEnable = 1'b0;
  logic usedEvent = 1'b0;
  logic [1:0] usedQueue = 2'h0;
  logic configChangeEvent = 1'b0;
  wire cyc, stb, we, ack, lineIrq, msgRequest, dbValid, dbExt, dbCookie;
  wire dbWrap;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] datW, datR, ringBaseBytes;
  wire [10:0] msgVector, msgTableSize;
  wire [1:0] ringChooser;
  wire [15:0] dbId;
  wire [14:0] dbOff;
  int nErrors = 0, checksDone = 0, cycles = 0, msgCount = 0, dbCount = 0;
  logic [10:0] lastVec = 11'h0;
  logic [31:0] dbWord = 32'h0, r;
  logic [1:0] dbFlags = 2'h0;
  always #50 clock = ~clock;
  host_driver_model i_host_driver_model (.clock(clock), .ack(ack),
    .datIn(datR), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .datOut(datW));
  pci_vq_event_notify_logic i_pci_vq_event_notify_logic (.clock(clock),
    .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .msgEnable(msgEnable), .usedEvent(usedEvent),
    .usedQueue(usedQueue), .configChangeEvent(configChangeEvent),
    .lineIrq(lineIrq), .msgRequest(msgRequest), .msgVector(msgVector),
    .msgTableSize(msgTableSize), .doorbellValid(dbValid),
    .doorbellExtended(dbExt), .doorbellIsCookie(dbCookie),
    .doorbell_queue_id(dbId), .doorbellNextOff(dbOff),
    .doorbellWrap(dbWrap), .ringChooser(ringChooser),
    .ringBaseBytes(ringBaseBytes));
  // Pulses last one cycle, so latch them as they pass
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (msgRequest === 1'b1) begin
      msgCount++;
      lastVec = msgVector;
    end
    if (dbValid === 1'b1) begin
      dbCount++;
      dbWord = {dbWrap, dbOff, dbId};
      dbFlags = {dbExt, dbCookie};
    end
    if (cycles == 3000) begin
      nErrors++;
      wrapUp();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checksDone++;
    if (got !== want) begin
      nErrors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic expectReg(input logic [7:0] a, input logic [31:0] want);
    i_host_driver_model.rd(a, r);
    check(r, want);
  endtask
  // Event pulse, then the fixed one-cycle answer plus margin
  task automatic pulse(input logic u, input logic c, input logic [1:0] q);
    @(posedge clock);
    usedEvent <= u;
    configChangeEvent <= c;
    usedQueue <= q;
    @(posedge clock);
    usedEvent <= 1'b0;
    configChangeEvent <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic regScenario();
    expectReg(`OFS_CONFIG_VECTOR, 32'hffff);
    expectReg(`OFS_QUEUE_VECTOR, 32'hffff);
    expectReg(`OFS_QUEUE_DEPTH, 32'h100);
    expectReg(`OFS_TABLE_SIZE, 32'h7);
    i_host_driver_model.mapVector(`OFS_CONFIG_VECTOR, 16'h3, r);
    check(r, 32'h3);
    i_host_driver_model.wr(`OFS_RING_CHOOSER, 32'h1, 4'hf);
    i_host_driver_model.mapVector(`OFS_QUEUE_VECTOR, 16'h8, r);
    check(r, 32'hffff);
    i_host_driver_model.mapVector(`OFS_QUEUE_VECTOR, 16'h7, r);
    check(r, 32'h7);
    i_host_driver_model.mapVector(`OFS_QUEUE_VECTOR, 16'h5, r);
    check(r, 32'h5);
    i_host_driver_model.wr(`OFS_QUEUE_DEPTH, 32'h40, 4'hf);
    expectReg(`OFS_QUEUE_DEPTH, 32'h40);
    i_host_driver_model.wr(`OFS_RING_BASE, 32'h12345, 4'hf);
    @(negedge clock);
    check(ringBaseBytes, 32'h12345000);
    check({30'h0, ringChooser}, 32'h1);
    i_host_driver_model.wr(`OFS_RING_CHOOSER, 32'h2, 4'hf);
    expectReg(`OFS_QUEUE_VECTOR, 32'hffff);
    i_host_driver_model.wr(`OFS_RING_CHOOSER, 32'h5, 4'hf);
    expectReg(`OFS_QUEUE_DEPTH, 32'h0);
  endtask
  task automatic legacyScenario();
    pulse(1'b1, 1'b0, 2'h1);
    expectReg(`OFS_CAUSE, 32'h1);
    pulse(1'b0, 1'b1, 2'h0);
    @(negedge clock);
    check({31'h0, lineIrq}, 32'h1);
    expectReg(`OFS_CAUSE, 32'h2);
    expectReg(`OFS_CAUSE, 32'h0);
    @(negedge clock);
    check({31'h0, lineIrq}, 32'h0);
  endtask
  task automatic msgScenario();
    @(posedge clock);
    msgEnable <= 1'b1;
    pulse(1'b1, 1'b0, 2'h1);
    check(msgCount, 1);
    check({21'h0, lastVec}, 32'h5);
    pulse(1'b1, 1'b0, 2'h2);
    check(msgCount, 1);
    pulse(1'b0, 1'b1, 2'h0);
    check({21'h0, lastVec}, 32'h3);
    i_host_driver_model.mapVector(`OFS_CONFIG_VECTOR, 16'hffff, r);
    check(r, 32'hffff);
    pulse(1'b0, 1'b1, 2'h0);
    check(msgCount, 2);
    expectReg(`OFS_CAUSE, 32'h0);
  endtask
  task automatic doorbellScenario();
    i_host_driver_model.ring(1'b0, 16'h2, 15'h0, 1'b0);
    // The pulse is latched on the ack edge; look after it settles
    @(negedge clock);
    check(dbCount, 1);
    check({dbFlags, dbWord[15:0]}, 32'h2);
    i_host_driver_model.wr(`OFS_FEATURE_CTRL, 32'h3, 4'hf);
    i_host_driver_model.ring(1'b1, 16'h2, 15'h5, 1'b1);
    @(negedge clock);
    check(dbWord, 32'h80050002);
    check({30'h0, dbFlags}, 32'h3);
  endtask
  // Mid-run reset must unmap and restore the banked queue 1
  task automatic resetScenario();
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    i_host_driver_model.wr(`OFS_RING_CHOOSER, 32'h1, 4'hf);
    expectReg(`OFS_QUEUE_VECTOR, 32'hffff);
    expectReg(`OFS_QUEUE_DEPTH, 32'h100);
  endtask
  task automatic wrapUp();
    $display("Errors %0d, checks %0d", nErrors, checksDone);
    if (nErrors == 0 && checksDone > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    regScenario();
    legacyScenario();
    msgScenario();
    doorbellScenario();
    resetScenario();
    wrapUp();
  end
endmodule
